// ===== hw/ofnrs_pkg.sv
package ofnrs_pkg;
    localparam int NUM_UNITS = 10;
    localparam int UNIT_W = 4;
    localparam int SEC_W = 7;
    localparam int ADDR_W = 14;
    localparam int RATE_W = 3;
    localparam logic [SEC_W-1:0] HOLD_DEFAULT_SEC = 7'h0a;
    localparam logic [SEC_W-1:0] HOLD_MIN_SEC = 7'h01;
    localparam logic [SEC_W-1:0] HOLD_MAX_SEC = 7'h63;
    localparam logic [ADDR_W-1:0] BASE_MD_0 = 14'h03e8;
    localparam logic [ADDR_W-1:0] BASE_MD_1 = 14'h0bb8;
    localparam logic [ADDR_W-1:0] BASE_MD_2 = 14'h1388;
    localparam logic [ADDR_W-1:0] BASE_MD_3 = 14'h1b58;
    localparam logic [ADDR_W-1:0] BASE_P2P = 14'h0000;
    localparam logic [RATE_W-1:0] CHAIN_RATE_RESET = 3'h0;
    localparam longint TICK_PERIOD_NS = 1000000000;
    localparam longint CLK_PERIOD_NS = 100;
    localparam int TICK_CYCLES = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);

    typedef struct packed {
        logic [SEC_W-1:0] backup_sec;
        logic [SEC_W-1:0] restore_sec;
    } ofnrs_hold_t;

    typedef struct packed {
        logic valid;
        logic [UNIT_W-1:0] unit;
    } ofnrs_sel_t;

    typedef enum logic [1:0] {
        OFNRS_IDLE,
        OFNRS_BRIDGE,
        OFNRS_BACKUP
    } ofnrs_state_t;
endpackage

// ===== hw/ofnrs_tick.sv
`timescale 1ns/1ps
module ofnrs_tick #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    logic [31:0] cnt_reg;
    logic tick_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 32'h0;
            tick_reg <= 1'b0;
        end else if (cnt_reg == 32'(TICK_CYCLES - 1)) begin
            cnt_reg <= 32'h0;
            tick_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
            tick_reg <= 1'b0;
        end
    end

    assign tick = tick_reg;
endmodule // ofnrs_tick

// ===== hw/ofnrs_holdoff.sv
`timescale 1ns/1ps
module ofnrs_holdoff (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic qual,
    input wire logic [ofnrs_pkg::SEC_W-1:0] reload_sec,
    output logic expired
);
    // One extra count makes the first, partial second not count toward the holdoff.
    logic [ofnrs_pkg::SEC_W:0] cnt_reg;
    logic [ofnrs_pkg::SEC_W:0] cnt_next;
    logic [ofnrs_pkg::SEC_W:0] load_val;

    assign load_val = {1'b0, reload_sec} + {{ofnrs_pkg::SEC_W{1'b0}}, 1'b1};
    assign cnt_next = !qual ? load_val :
        (tick && cnt_reg != '0) ? cnt_reg - {{ofnrs_pkg::SEC_W{1'b0}}, 1'b1} : cnt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= {1'b0, ofnrs_pkg::HOLD_DEFAULT_SEC};
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign expired = qual && cnt_reg == '0;
endmodule // ofnrs_holdoff

// ===== hw/ofnrs_switch.sv
`timescale 1ns/1ps
module ofnrs_switch #(
    parameter int TICK_CYCLES = ofnrs_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [ofnrs_pkg::NUM_UNITS-1:0] unit_fault_in,
    input wire logic spare_fault_in,
    input wire logic [ofnrs_pkg::NUM_UNITS-1:0] active_mask,
    input wire logic auto_mode_sel,
    input wire logic mode_wr,
    input wire ofnrs_pkg::ofnrs_hold_t hold_cfg,
    input wire logic hold_wr,
    input wire ofnrs_pkg::ofnrs_sel_t man_bridge,
    input wire ofnrs_pkg::ofnrs_sel_t man_backup,
    input wire logic remote_multidrop,
    input wire logic [ofnrs_pkg::ADDR_W-1:0] panel_set_address,
    input wire logic addr_wr,
    input wire logic [ofnrs_pkg::RATE_W-1:0] chain_rate_cfg,
    input wire logic chain_cfg_wr,
    input wire logic remote_req_valid,
    input wire logic [ofnrs_pkg::ADDR_W-1:0] remote_req_addr,
    output logic auto_mode,
    output logic stored_event_led,
    output ofnrs_pkg::ofnrs_sel_t bridge_out,
    output ofnrs_pkg::ofnrs_sel_t backup_out,
    output ofnrs_pkg::ofnrs_hold_t hold_out,
    output logic [ofnrs_pkg::ADDR_W-1:0] remote_base_addr,
    output logic addr_reject,
    output logic [ofnrs_pkg::RATE_W-1:0] chain_rate,
    output logic chain_fwd_valid,
    output logic [ofnrs_pkg::UNIT_W-1:0] chain_fwd_unit,
    output logic [ofnrs_pkg::ADDR_W-1:0] chain_fwd_addr,
    output logic spare_req_valid,
    output logic poll_strobe,
    output logic [ofnrs_pkg::UNIT_W-1:0] poll_unit
);
    localparam int N = ofnrs_pkg::NUM_UNITS;
    localparam int UW = ofnrs_pkg::UNIT_W;
    localparam int AW = ofnrs_pkg::ADDR_W;

    function automatic logic base_ok(input logic multidrop, input logic [AW-1:0] a);
        if (multidrop) begin
            base_ok = a == ofnrs_pkg::BASE_MD_0 || a == ofnrs_pkg::BASE_MD_1 ||
                a == ofnrs_pkg::BASE_MD_2 || a == ofnrs_pkg::BASE_MD_3;
        end else begin
            base_ok = a == ofnrs_pkg::BASE_P2P;
        end
    endfunction

    // Lowest set bit wins, which makes the scan order the tie-break for simultaneous faults.
    function automatic logic [UW:0] first_set(input logic [N-1:0] v);
        first_set = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = {1'b1, UW'(i)};
            end
        end
    endfunction

    function automatic logic hold_ok(input logic [ofnrs_pkg::SEC_W-1:0] s);
        hold_ok = s >= ofnrs_pkg::HOLD_MIN_SEC && s <= ofnrs_pkg::HOLD_MAX_SEC;
    endfunction

    logic rst_meta_reg;
    logic rst_n;
    logic [N-1:0] fault_meta_reg;
    logic [N-1:0] fault_reg;
    logic spare_meta_reg;
    logic spare_f;
    logic tick;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_meta_reg <= '0;
            fault_reg <= '0;
            spare_meta_reg <= 1'b0;
            spare_f <= 1'b0;
        end else begin
            fault_meta_reg <= unit_fault_in;
            fault_reg <= fault_meta_reg;
            spare_meta_reg <= spare_fault_in;
            spare_f <= spare_meta_reg;
        end
    end

    ofnrs_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick)
    );

    logic auto_reg;
    ofnrs_pkg::ofnrs_hold_t hold_reg;
    ofnrs_pkg::ofnrs_state_t state_reg;
    ofnrs_pkg::ofnrs_state_t state_next;
    logic [UW-1:0] unit_reg;
    logic [UW-1:0] unit_next;
    logic [N-1:0] bk_qual;
    logic [N-1:0] bk_exp;
    logic [N-1:0] rs_qual;
    logic [N-1:0] rs_exp;

    // A unit qualifies for backup only while active, faulted, and the spare is healthy.
    assign bk_qual = active_mask & fault_reg & {N{auto_reg && !spare_f}};
    assign rs_qual = ~fault_reg & {N{auto_reg}};

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_hold
            ofnrs_holdoff u_bk (
                .clk(clk),
                .rst_n(rst_n),
                .tick(tick),
                .qual(bk_qual[g]),
                .reload_sec(hold_reg.backup_sec),
                .expired(bk_exp[g])
            );
            ofnrs_holdoff u_rs (
                .clk(clk),
                .rst_n(rst_n),
                .tick(tick),
                .qual(rs_qual[g]),
                .reload_sec(hold_reg.restore_sec),
                .expired(rs_exp[g])
            );
        end
    endgenerate

    logic [UW:0] cand_any;
    logic [UW:0] cand_other;
    logic [N-1:0] other_mask;
    logic cur_fault;
    logic cur_active;
    logic man_bk_ok;
    logic man_br_ok;

    assign cand_any = first_set(bk_exp);
    assign other_mask = ~(N'(1) << unit_reg);
    assign cand_other = first_set(bk_exp & other_mask);
    assign cur_fault = fault_reg[unit_reg];
    assign cur_active = active_mask[unit_reg];
    assign man_bk_ok = man_backup.valid && active_mask[man_backup.unit] && !spare_f;
    assign man_br_ok = man_bridge.valid && active_mask[man_bridge.unit];

    always_comb begin
        state_next = state_reg;
        unit_next = unit_reg;
        if (!auto_reg) begin
            // Operator picks act at once; unit faults are not looked at here, but a backup pick needs a healthy spare.
            if (man_bk_ok) begin
                state_next = ofnrs_pkg::OFNRS_BACKUP;
                unit_next = man_backup.unit;
            end else if (man_br_ok) begin
                state_next = ofnrs_pkg::OFNRS_BRIDGE;
                unit_next = man_bridge.unit;
            end else begin
                state_next = ofnrs_pkg::OFNRS_IDLE;
            end
        end else begin
            unique case (state_reg)
                ofnrs_pkg::OFNRS_IDLE: begin
                    if (cand_any[UW]) begin
                        state_next = ofnrs_pkg::OFNRS_BRIDGE;
                        unit_next = cand_any[UW-1:0];
                    end
                end
                ofnrs_pkg::OFNRS_BRIDGE: begin
                    // The spare gets one tick to lock before the switchover is committed.
                    if (!cur_fault || !cur_active) begin
                        state_next = ofnrs_pkg::OFNRS_IDLE;
                    end else if (tick && !spare_f) begin
                        state_next = ofnrs_pkg::OFNRS_BACKUP;
                    end
                end
                ofnrs_pkg::OFNRS_BACKUP: begin
                    if (spare_f && rs_exp[unit_reg]) begin
                        state_next = ofnrs_pkg::OFNRS_IDLE;
                    end else if (cand_other[UW] && rs_exp[unit_reg]) begin
                        state_next = ofnrs_pkg::OFNRS_BRIDGE;
                        unit_next = cand_other[UW-1:0];
                    end
                    // Otherwise the recovered unit stays offline.
                end
                default: begin
                    state_next = ofnrs_pkg::OFNRS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_reg <= 1'b0;
            hold_reg <= {ofnrs_pkg::HOLD_DEFAULT_SEC, ofnrs_pkg::HOLD_DEFAULT_SEC};
            state_reg <= ofnrs_pkg::OFNRS_IDLE;
            unit_reg <= '0;
        end else begin
            if (mode_wr) begin
                auto_reg <= auto_mode_sel;
            end
            if (hold_wr && hold_ok(hold_cfg.backup_sec) && hold_ok(hold_cfg.restore_sec)) begin
                hold_reg <= hold_cfg;
            end
            state_reg <= state_next;
            unit_reg <= unit_next;
        end
    end

    logic blink_reg;
    logic led_reg;
    logic led_next;
    ofnrs_pkg::ofnrs_sel_t bridge_reg;
    ofnrs_pkg::ofnrs_sel_t backup_reg;

    // In automatic mode the indicator is steady and marks a backup in progress.
    assign led_next = auto_reg ? state_reg == ofnrs_pkg::OFNRS_BACKUP : blink_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_reg <= 1'b0;
            led_reg <= 1'b0;
            bridge_reg <= '0;
            backup_reg <= '0;
        end else begin
            if (tick) begin
                blink_reg <= !blink_reg;
            end
            led_reg <= led_next;
            bridge_reg <= '{valid: state_reg != ofnrs_pkg::OFNRS_IDLE, unit: unit_reg};
            backup_reg <= '{valid: state_reg == ofnrs_pkg::OFNRS_BACKUP, unit: unit_reg};
        end
    end

    logic [AW-1:0] base_reg;
    logic reject_reg;
    logic [ofnrs_pkg::RATE_W-1:0] chain_rate_reg;
    logic [AW-1:0] req_off;
    logic req_in_chain;
    logic fwd_valid_reg;
    logic [UW-1:0] fwd_unit_reg;
    logic [AW-1:0] fwd_addr_reg;
    logic spare_req_reg;

    // Unit k answers at base + k + 1; the base itself names the spare controller.
    assign req_off = remote_req_addr - base_reg;
    assign req_in_chain = remote_req_addr > base_reg && req_off <= AW'(N);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_reg <= ofnrs_pkg::BASE_P2P;
            reject_reg <= 1'b0;
            chain_rate_reg <= ofnrs_pkg::CHAIN_RATE_RESET;
            fwd_valid_reg <= 1'b0;
            fwd_unit_reg <= '0;
            fwd_addr_reg <= '0;
            spare_req_reg <= 1'b0;
        end else begin
            reject_reg <= addr_wr && !base_ok(remote_multidrop, panel_set_address);
            if (addr_wr && base_ok(remote_multidrop, panel_set_address)) begin
                base_reg <= panel_set_address;
            end
            if (chain_cfg_wr) begin
                chain_rate_reg <= chain_rate_cfg;
            end
            fwd_valid_reg <= remote_req_valid && req_in_chain;
            spare_req_reg <= remote_req_valid && remote_req_addr == base_reg;
            if (remote_req_valid && req_in_chain) begin
                fwd_unit_reg <= UW'(req_off - AW'(1));
                fwd_addr_reg <= remote_req_addr;
            end
        end
    end

    logic poll_reg;
    logic [UW-1:0] poll_unit_reg;
    logic [UW:0] poll_pick;
    logic [N-1:0] poll_above;

    assign poll_above = active_mask & ~((N'(2) << poll_unit_reg) - N'(1));
    assign poll_pick = poll_above != '0 ? first_set(poll_above) : first_set(active_mask);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            poll_reg <= 1'b0;
            poll_unit_reg <= '0;
        end else begin
            poll_reg <= tick && poll_pick[UW];
            if (tick && poll_pick[UW]) begin
                poll_unit_reg <= poll_pick[UW-1:0];
            end
        end
    end

    assign auto_mode = auto_reg;
    assign stored_event_led = led_reg;
    assign bridge_out = bridge_reg;
    assign backup_out = backup_reg;
    assign hold_out = hold_reg;
    assign remote_base_addr = base_reg;
    assign addr_reject = reject_reg;
    assign chain_rate = chain_rate_reg;
    assign chain_fwd_valid = fwd_valid_reg;
    assign chain_fwd_unit = fwd_unit_reg;
    assign chain_fwd_addr = fwd_addr_reg;
    assign spare_req_valid = spare_req_reg;
    assign poll_strobe = poll_reg;
    assign poll_unit = poll_unit_reg;

    sequence s_auto_bridge;
        auto_reg && state_reg == ofnrs_pkg::OFNRS_IDLE
            ##1 state_reg == ofnrs_pkg::OFNRS_BRIDGE;
    endsequence

    sequence s_bridge_drop;
        auto_reg && state_reg == ofnrs_pkg::OFNRS_BRIDGE && !cur_fault;
    endsequence

    a_start_manual: assert property (@(posedge clk) $rose(rst_n) |-> !auto_reg)
        else $error("Controller did not start in manual mode.");
    a_led_follows_mode: assert property (@(posedge clk) disable iff (!rst_n)
        $past(auto_reg) && auto_reg |-> led_reg == $past(state_reg == ofnrs_pkg::OFNRS_BACKUP))
        else $error("Indicator not steady in automatic mode.");
    a_led_blinks_manual: assert property (@(posedge clk) disable iff (!rst_n)
        !auto_reg && tick ##1 !auto_reg ##1 !auto_reg |-> led_reg != $past(led_reg, 2))
        else $error("Indicator did not flash in manual mode.");
    // The chosen unit is only known after the edge, so the past expiry vector is indexed by it.
    a_bridge_after_hold: assert property (@(posedge clk) disable iff (!rst_n)
        s_auto_bridge |-> ($past(bk_exp) & (N'(1) << unit_reg)) != '0 && $past(!spare_f))
        else $error("Bridge before backup holdoff elapsed.");
    a_cancel_on_clear: assert property (@(posedge clk) disable iff (!rst_n)
        s_bridge_drop ##1 auto_reg |-> state_reg == ofnrs_pkg::OFNRS_IDLE)
        else $error("Transfer not cancelled after fault cleared.");
    a_no_spare_switch: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg != ofnrs_pkg::OFNRS_BACKUP ##1 state_reg == ofnrs_pkg::OFNRS_BACKUP
            |-> $past(!spare_f))
        else $error("Traffic switched onto a faulted spare.");
    a_addr_reject: assert property (@(posedge clk) disable iff (!rst_n)
        addr_wr && !base_ok(remote_multidrop, panel_set_address)
            |=> reject_reg && $stable(base_reg))
        else $error("Illegal base address was accepted.");
    a_relay_unit: assert property (@(posedge clk) disable iff (!rst_n)
        remote_req_valid && remote_req_addr == base_reg + AW'(1) && $stable(base_reg)
            |=> fwd_valid_reg && fwd_unit_reg == '0 && !spare_req_reg)
        else $error("First unit address not relayed over the chain bus.");
    a_poll_active: assert property (@(posedge clk) disable iff (!rst_n)
        poll_reg |-> ($past(active_mask) & (N'(1) << poll_unit_reg)) != '0)
        else $error("Inactive unit was polled.");
endmodule // ofnrs_switch

// ===== tb/ofnrs_far_model.sv
`timescale 1ns/1ps
module ofnrs_far_model (
    input wire logic clk,
    input wire logic [ofnrs_pkg::NUM_UNITS-1:0] unit_cmd,
    input wire logic spare_cmd,
    output logic [ofnrs_pkg::NUM_UNITS-1:0] unit_fault,
    output logic spare_fault
);
    // Units only report status levels; remote traffic never reaches them here.
    always @(negedge clk) begin
        unit_fault <= unit_cmd;
        spare_fault <= spare_cmd;
    end
endmodule // ofnrs_far_model

// ===== tb/test_ofnrs_switch.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_ofnrs_switch;
    localparam int TK = 20;
    logic clk = 0, arst_n = 0, spare_f, scmd = 0, mode_wr = 0, auto_sel = 0;
    logic hold_wr = 0, md = 1, addr_wr = 0, ccw = 0, rq = 0, auto_mode, led;
    logic rej, fwd_v, spr_v, poll_s, rej_seen = 0, spr_seen = 0;
    logic [9:0] uf, ucmd = '0, act = 10'h3ef, poll_seen = '0;
    logic [13:0] psa = '0, rq_a = '0, base, fwd_a;
    logic [2:0] rate_cfg = '0, rate;
    logic [3:0] fwd_u, poll_u, fwd_seen = '0;
    ofnrs_pkg::ofnrs_hold_t hcfg = '0, hout;
    ofnrs_pkg::ofnrs_sel_t mbr = '0, mbk = '0, br, bk;
    int error_cnt = 0, tests_run = 0;
    ofnrs_far_model far (.clk(clk), .unit_cmd(ucmd), .spare_cmd(scmd),
        .unit_fault(uf), .spare_fault(spare_f));
    ofnrs_switch #(.TICK_CYCLES(TK)) dut (.clk(clk), .arst_n(arst_n), .unit_fault_in(uf),
        .spare_fault_in(spare_f), .active_mask(act), .auto_mode_sel(auto_sel),
        .mode_wr(mode_wr), .hold_cfg(hcfg), .hold_wr(hold_wr), .man_bridge(mbr),
        .man_backup(mbk), .remote_multidrop(md), .panel_set_address(psa),
        .addr_wr(addr_wr), .chain_rate_cfg(rate_cfg), .chain_cfg_wr(ccw),
        .remote_req_valid(rq), .remote_req_addr(rq_a), .auto_mode(auto_mode),
        .stored_event_led(led), .bridge_out(br), .backup_out(bk), .hold_out(hout),
        .remote_base_addr(base), .addr_reject(rej), .chain_rate(rate),
        .chain_fwd_valid(fwd_v), .chain_fwd_unit(fwd_u), .chain_fwd_addr(fwd_a),
        .spare_req_valid(spr_v), .poll_strobe(poll_s), .poll_unit(poll_u));
    initial forever #50 clk = ~clk;
    // Pulses are caught mid-cycle, well away from the edge that launches them.
    always @(negedge clk) begin
        if (rej) rej_seen <= 1'b1;
        if (spr_v) spr_seen <= 1'b1;
        if (fwd_v) fwd_seen <= fwd_u;
        if (poll_s) poll_seen[poll_u] <= 1'b1;
    end
    function automatic ofnrs_pkg::ofnrs_sel_t sel(input logic [3:0] u);
        return ofnrs_pkg::ofnrs_sel_t'({1'b1, u});
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(2);
    endtask
    // An invalid selection names no unit, so it is compared as all zero.
    function automatic ofnrs_pkg::ofnrs_sel_t norm(input ofnrs_pkg::ofnrs_sel_t s);
        return s.valid ? s : '0;
    endfunction
    // Polls one output for up to the given ticks, then compares what was last seen.
    task automatic wait_sel(input logic use_bk, input ofnrs_pkg::ofnrs_sel_t e, input int t);
        for (int i = 0; i < t * TK && norm(use_bk ? bk : br) !== e; i++) cyc(1);
        `CHK("sel", e, norm(use_bk ? bk : br))
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    logic l;
    logic [13:0] mdb [4] = '{ofnrs_pkg::BASE_MD_0, ofnrs_pkg::BASE_MD_1,
        ofnrs_pkg::BASE_MD_2, ofnrs_pkg::BASE_MD_3};
    initial begin
        cyc(3);
        arst_n = 1'b1;
        cyc(3);
        `CHK("mode", 1'b0, auto_mode)
        `CHK("hold", 14'h050a, hout)
        l = led;
        cyc(TK + 1);
        `CHK("led", ~l, led)
        hcfg = 14'h0000; pulse(hold_wr); `CHK("hold0", 14'h050a, hout)
        hcfg = 14'h3264; pulse(hold_wr); `CHK("hold100", 14'h050a, hout)
        hcfg = 14'h31e3; pulse(hold_wr); `CHK("hold_mm", 14'h31e3, hout)
        hcfg = 14'h0102; pulse(hold_wr); `CHK("hold2", 14'h0102, hout)
        for (int i = 0; i < 4; i++) begin
            psa = mdb[i]; pulse(addr_wr); `CHK("base", mdb[i], base)
        end
        psa = 14'h07d0; pulse(addr_wr); `CHK("rej", 1'b1, rej_seen)
        `CHK("base_kept", mdb[3], base)
        md = 1'b0; psa = '0; pulse(addr_wr); `CHK("p2p", 14'h0000, base)
        md = 1'b1; psa = mdb[0]; pulse(addr_wr);
        rate_cfg = 3'h5; pulse(ccw); `CHK("rate", 3'h5, rate)
        `CHK("base_sep", mdb[0], base)
        rq_a = mdb[0] + 14'h0003; pulse(rq); `CHK("fwd", 4'h2, fwd_seen)
        `CHK("fwd_a", rq_a, fwd_a)
        rq_a = mdb[0] + 14'h0001; pulse(rq); `CHK("fwd0", 4'h0, fwd_seen)
        rq_a = mdb[0]; pulse(rq); `CHK("spare", 1'b1, spr_seen)
        ucmd = 10'h020; mbr = sel(4'h3); cyc(6); `CHK("mbr", sel(4'h3), br)
        `CHK("mbk0", 1'b0, bk.valid)
        scmd = 1'b1; cyc(4);
        mbk = sel(4'h3); cyc(6); `CHK("mbk_sf", 1'b0, bk.valid)
        scmd = 1'b0; cyc(6); `CHK("mbk", sel(4'h3), bk)
        mbr = '0; mbk = '0; ucmd = '0;
        auto_sel = 1'b1; pulse(mode_wr); `CHK("auto", 1'b1, auto_mode)
        cyc(2 * TK); `CHK("led_auto", 1'b0, led)
        ucmd = 10'h010; cyc(5 * TK); `CHK("inact", 1'b0, br.valid)
        ucmd = 10'h004; cyc(TK); ucmd = '0; cyc(4 * TK);
        `CHK("cancel", 1'b0, br.valid)
        ucmd = 10'h004; cyc(TK + TK / 2); `CHK("early", 1'b0, br.valid)
        wait_sel(1'b0, sel(4'h2), 3);
        wait_sel(1'b1, sel(4'h2), 2);
        `CHK("led_bk", 1'b1, led)
        ucmd = '0; cyc(5 * TK); `CHK("stay", sel(4'h2), bk)
        scmd = 1'b1; wait_sel(1'b1, '0, 5);
        scmd = 1'b0; ucmd = 10'h004;
        wait_sel(1'b1, sel(4'h2), 6);
        ucmd = 10'h040;
        wait_sel(1'b0, sel(4'h6), 8);
        ucmd = '0; cyc(TK); `CHK("cancel2", 1'b0, br.valid)
        `CHK("cancel2_bk", 1'b0, bk.valid)
        `CHK("poll", 10'h3ef, poll_seen)
        end_sim();
    end
    initial begin
        #2ms;
        error_cnt++;
        end_sim();
    end
endmodule // test_ofnrs_switch
